// ===== logic/serial_chan_pkg.sv
// Constants shared by the serial channel control block
package serial_chan_pkg;
	localparam int DATA_W = 8;
	localparam int SYNC_STAGES = 2;
	// Port offsets within the two-port block, default placement
	localparam logic SERIAL_DATA_PORT_OFS = 1'h0;
	localparam logic CHANNEL_STATUS_PORT_OFS = 1'h1;
	localparam logic CHANNEL_CONTROL_PORT_OFS = 1'h1;
	// Control word fields
	localparam int CTL_RX_IRQ_ENABLE = 0;
	localparam int CTL_TX_IRQ_ENABLE = 1;
	localparam int CTL_CD = 2;
	localparam int CTL_CA = 3;
	localparam int CTL_STOP_BIT_COUNT = 4;
	localparam int CTL_PARITY_INHIBIT = 5;
	localparam int CTL_PARITY_EVEN = 6;
	localparam int CTL_CHAR_LENGTH = 7;
	// Status word fields
	localparam int STS_TX_HOLDING_EMPTY = 0;
	localparam int STS_RX_CHAR_READY = 1;
	localparam int STS_OPTIONAL_INPUT = 2;
	localparam int STS_PARITY_FAULT = 3;
	localparam int STS_OVERRUN = 4;
	localparam int STS_FRAMING_FAULT = 5;
	localparam int STS_CC = 6;
	localparam int STS_CB = 7;
	// Values after reset
	localparam logic [7:0] CTRL_LATCH_RESET = 8'h00;
	localparam logic [7:0] RDATA_RESET = 8'h00;
	localparam logic [1:0] RST_SYNC_RESET = 2'h0;
endpackage

// ===== logic/dual_serial_channel_ctrl.sv
// Control, status and interrupt logic of one serial channel
// How it works
// - A control port write loads all eight control latches together
// - A latch bit at one inverts its signal against the jumper level
// - A latch bit at zero gives the jumper power-up level
// - Receive interrupt pulled low while character unread and receive enable active
// - Receive interrupt released once the host reads the data port
// - Transmit interrupt pulled low while UART can take a character and enabled
// - Transmit interrupt released while the transmit holding buffer is full
// - Bus interrupt-acknowledge status is not an input at all
// - Bits 0 and 1 toggle receive and transmit interrupt enables
// - Bit 2 drives the CD output, bit 3 the CA output
// - Status bit 6 shows CC input, bit 7 shows CB input
// - Handshake outputs start at jumper level and writes change them
// - Status bit 2 shows CF or UART end-of-character by option
// - Jumpers choose parity, length, stop bits, inhibit, interrupts, handshake
// - Control bits: rx en, tx en, CD, CA, stops, inhibit, even, length
// - Status bits: tx empty, rx ready, option, parity, overrun, framing, CC, CB
// - Power-on clear or bus reset clears every control latch
// - Data port at base, status at base plus one; option swaps them
`timescale 1ns/1ps
module dual_serial_channel_ctrl (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	input wire logic power_on_clear_n,
	input wire logic bus_reset_n,
	// Host port access, same clock
	input wire logic io_sel,
	input wire logic io_addr0,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [serial_chan_pkg::DATA_W-1:0] io_wdata,
	output logic [serial_chan_pkg::DATA_W-1:0] io_rdata,
	output logic io_rdata_oe,
	// Jumper straps
	input wire logic [7:0] powerup_levels,
	input wire logic port_swap,
	input wire logic opt_select_eoc,
	// UART side
	input wire logic [serial_chan_pkg::DATA_W-1:0] uart_rx_data,
	input wire logic uart_rx_char_ready,
	input wire logic uart_tx_holding_empty,
	input wire logic uart_parity_fault,
	input wire logic uart_overrun,
	input wire logic uart_framing_fault,
	input wire logic uart_end_of_char,
	output logic uart_rx_read,
	output logic uart_tx_load,
	output logic [serial_chan_pkg::DATA_W-1:0] uart_tx_data,
	// UART format controls
	output logic stop_bit_count_select,
	output logic parity_inhibit,
	output logic parity_even_select,
	output logic char_length_select,
	// Handshake lines
	output logic cd_out,
	output logic ca_out,
	input wire logic cc_in,
	input wire logic cb_in,
	input wire logic cf_in,
	// Open-drain interrupt lines
	output logic rx_irq_line_out,
	output logic rx_irq_line_oe,
	output logic tx_irq_line_out,
	output logic tx_irq_line_oe
);
	import serial_chan_pkg::*;

	localparam int NSYNC = 8 + 8 + 10;

	// Reset release
	logic [1:0] rst_sync_reg;
	logic rst_n;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_reg <= RST_SYNC_RESET;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// Two-stage synchronisers for pins and UART signals
	logic [NSYNC-1:0] sync_raw;
	logic [NSYNC-1:0] sync1_reg;
	logic [NSYNC-1:0] sync2_reg;
	assign sync_raw = {powerup_levels, uart_rx_data, power_on_clear_n, bus_reset_n, port_swap,
		opt_select_eoc, uart_rx_char_ready, uart_tx_holding_empty, uart_parity_fault,
		uart_overrun, uart_framing_fault, uart_end_of_char};
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= sync_raw;
			sync2_reg <= sync1_reg;
		end
	end
	logic [2:0] hs1_reg;
	logic [2:0] hs2_reg;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hs1_reg <= '0;
			hs2_reg <= '0;
		end else begin
			hs1_reg <= {cc_in, cb_in, cf_in};
			hs2_reg <= hs1_reg;
		end
	end

	logic [7:0] level_s;
	logic [7:0] rxd_s;
	logic poc_n_s, bres_n_s, swap_s, eoc_sel_s, dav_s, tx_holding_empty_s, pe_s, or_s, fe_s, eoc_s;
	assign level_s = sync2_reg[25:18];
	assign rxd_s = sync2_reg[17:10];
	assign {poc_n_s, bres_n_s, swap_s, eoc_sel_s, dav_s, tx_holding_empty_s, pe_s, or_s, fe_s, eoc_s} =
		sync2_reg[9:0];

	// Port decode
	function automatic logic is_data_port(input logic a0, input logic swap);
		return a0 == (swap ? CHANNEL_STATUS_PORT_OFS : SERIAL_DATA_PORT_OFS);
	endfunction
	logic data_wr, data_rd, ctrl_wr, stat_rd, latch_clear;
	assign data_wr = io_sel && io_wr && is_data_port(io_addr0, swap_s);
	assign data_rd = io_sel && io_rd && is_data_port(io_addr0, swap_s);
	assign ctrl_wr = io_sel && io_wr && !is_data_port(io_addr0, swap_s);
	assign stat_rd = io_sel && io_rd && !is_data_port(io_addr0, swap_s);
	assign latch_clear = !poc_n_s || !bres_n_s;

	// Status word
	logic [7:0] status_word;
	always_comb begin
		status_word = 8'h00;
		status_word[STS_TX_HOLDING_EMPTY] = tx_holding_empty_s;
		status_word[STS_RX_CHAR_READY] = dav_s;
		status_word[STS_OPTIONAL_INPUT] = eoc_sel_s ? eoc_s : hs2_reg[0];
		status_word[STS_PARITY_FAULT] = pe_s;
		status_word[STS_OVERRUN] = or_s;
		status_word[STS_FRAMING_FAULT] = fe_s;
		status_word[STS_CC] = hs2_reg[2];
		status_word[STS_CB] = hs2_reg[1];
	end

	// Channel state
	logic [7:0] ctrl_latch_reg, ctrl_latch_next;
	logic [7:0] ctrl_out_reg, ctrl_out_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [7:0] txd_reg, txd_next;
	logic oe_reg, oe_next, rx_rd_reg, rx_rd_next, tx_ld_reg, tx_ld_next;
	logic rx_taken_reg, rx_taken_next, tx_full_reg, tx_full_next;
	logic rx_irq_reg, rx_irq_next, tx_irq_reg, tx_irq_next;

	always_comb begin
		ctrl_latch_next = ctrl_latch_reg;
		if (latch_clear) begin
			ctrl_latch_next = CTRL_LATCH_RESET;
		end else if (ctrl_wr) begin
			ctrl_latch_next = io_wdata;
		end
		// Jumper level flipped by each set bit
		ctrl_out_next = ctrl_latch_next ^ level_s;
		rdata_next = rdata_reg;
		if (data_rd) begin
			rdata_next = rxd_s;
		end else if (stat_rd) begin
			rdata_next = status_word;
		end
		oe_next = data_rd || stat_rd;
		rx_rd_next = data_rd;
		tx_ld_next = data_wr;
		txd_next = data_wr ? io_wdata : txd_reg;
		// Read marks the character taken until the UART drops ready
		rx_taken_next = (rx_taken_reg && dav_s) || data_rd;
		// Load marks the buffer full until the UART drops empty
		tx_full_next = (tx_full_reg && tx_holding_empty_s) || data_wr;
		rx_irq_next = dav_s && !rx_taken_next &&
			ctrl_out_next[CTL_RX_IRQ_ENABLE];
		tx_irq_next = tx_holding_empty_s && !tx_full_next &&
			ctrl_out_next[CTL_TX_IRQ_ENABLE];
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_latch_reg <= CTRL_LATCH_RESET;
			ctrl_out_reg <= CTRL_LATCH_RESET;
			rdata_reg <= RDATA_RESET;
			txd_reg <= RDATA_RESET;
			oe_reg <= 1'b0;
			rx_rd_reg <= 1'b0;
			tx_ld_reg <= 1'b0;
			rx_taken_reg <= 1'b0;
			tx_full_reg <= 1'b0;
			rx_irq_reg <= 1'b0;
			tx_irq_reg <= 1'b0;
		end else begin
			ctrl_latch_reg <= ctrl_latch_next;
			ctrl_out_reg <= ctrl_out_next;
			rdata_reg <= rdata_next;
			txd_reg <= txd_next;
			oe_reg <= oe_next;
			rx_rd_reg <= rx_rd_next;
			tx_ld_reg <= tx_ld_next;
			rx_taken_reg <= rx_taken_next;
			tx_full_reg <= tx_full_next;
			rx_irq_reg <= rx_irq_next;
			tx_irq_reg <= tx_irq_next;
		end
	end

	// Outputs
	assign io_rdata = rdata_reg;
	assign io_rdata_oe = oe_reg;
	assign uart_rx_read = rx_rd_reg;
	assign uart_tx_load = tx_ld_reg;
	assign uart_tx_data = txd_reg;
	assign stop_bit_count_select = ctrl_out_reg[CTL_STOP_BIT_COUNT];
	assign parity_inhibit = ctrl_out_reg[CTL_PARITY_INHIBIT];
	assign parity_even_select = ctrl_out_reg[CTL_PARITY_EVEN];
	assign char_length_select = ctrl_out_reg[CTL_CHAR_LENGTH];
	assign cd_out = ctrl_out_reg[CTL_CD];
	assign ca_out = ctrl_out_reg[CTL_CA];
	assign rx_irq_line_out = 1'b0;
	assign rx_irq_line_oe = rx_irq_reg;
	assign tx_irq_line_out = 1'b0;
	assign tx_irq_line_oe = tx_irq_reg;

	// Checks
	sequence seq_data_read;
		data_rd;
	endsequence
	sequence seq_rx_release;
		##1 !rx_irq_line_oe;
	endsequence

	AST_CTRL_LOAD: assert property (@(posedge mclk) disable iff (!rst_n)
		ctrl_wr && !latch_clear |=> ctrl_latch_reg == $past(io_wdata))
		else $error("control word not loaded");
	AST_CTRL_LEVEL: assert property (@(posedge mclk) disable iff (!rst_n)
		ctrl_out_reg == (ctrl_latch_reg ^ $past(level_s)))
		else $error("control signal not latch xor jumper level");
	AST_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
		latch_clear |=> ctrl_latch_reg == 8'h00 && ctrl_out_reg == $past(level_s))
		else $error("clear did not restore power-up levels");
	AST_RX_IRQ: assert property (@(posedge mclk) disable iff (!rst_n)
		dav_s && !rx_taken_reg && !data_rd && ctrl_out_next[CTL_RX_IRQ_ENABLE]
		|=> rx_irq_line_oe)
		else $error("receive interrupt not asserted");
	AST_RX_RELEASE: assert property (@(posedge mclk) disable iff (!rst_n)
		seq_data_read |-> seq_rx_release)
		else $error("receive interrupt not released after read");
	AST_TX_IRQ: assert property (@(posedge mclk) disable iff (!rst_n)
		tx_irq_line_oe |-> $past(tx_holding_empty_s) && ctrl_out_reg[CTL_TX_IRQ_ENABLE])
		else $error("transmit interrupt without cause");
	AST_TX_RELEASE: assert property (@(posedge mclk) disable iff (!rst_n)
		!tx_holding_empty_s || data_wr |=> !tx_irq_line_oe)
		else $error("transmit interrupt held while buffer full");
	AST_STAT_READ: assert property (@(posedge mclk) disable iff (!rst_n)
		stat_rd |=> io_rdata_oe && io_rdata == $past(status_word) ##1 !io_rdata_oe || $past(io_rd))
		else $error("status read wrong");
	AST_DATA_READ: assert property (@(posedge mclk) disable iff (!rst_n)
		data_rd |=> uart_rx_read && io_rdata == $past(rxd_s))
		else $error("data read wrong");
endmodule // dual_serial_channel_ctrl

// ===== bench/uart_flag_model.sv
// Flag model of the UART that faces the channel
`timescale 1ns/1ps
module uart_flag_model (
	// Clock
	input wire logic mclk,
	// Strobes from channel and bench
	input wire logic uart_rx_read,
	input wire logic uart_tx_load,
	input wire logic rx_push,
	// UART flags
	output logic rx_char_ready,
	output logic tx_holding_empty
);
	logic [3:0] busy_reg;
	initial begin
		rx_char_ready = 1'b0;
		tx_holding_empty = 1'b1;
		busy_reg = 4'h0;
	end
	// Ready held until read; holding buffer busy 8 cycles after a load
	always @(posedge mclk) begin
		if (rx_push) rx_char_ready <= 1'b1;
		else if (uart_rx_read) rx_char_ready <= 1'b0;
		if (uart_tx_load) begin
			tx_holding_empty <= 1'b0;
			busy_reg <= 4'h8;
		end else if (busy_reg != 4'h0) begin
			busy_reg <= busy_reg - 4'h1;
			tx_holding_empty <= (busy_reg == 4'h1);
		end
	end
endmodule // uart_flag_model

// ===== bench/dual_serial_channel_ctrl_tb.sv
// Self-checking bench of the serial channel control block
`timescale 1ns/1ps
module dual_serial_channel_ctrl_tb;
	localparam logic [7:0] LV = 8'hA5;
	logic mclk, rstn, power_on_clear_n, bus_reset_n, io_sel, io_addr0, io_wr, io_rd;
	logic port_swap, opt_select_eoc, rdy, emp, pe, ov, fe, eoc, rd_p, ld, rx_push;
	logic cc_in, cb_in, cf_in, sb, pi, pev, cl, cd_out, ca_out, rxo, rxe, txo, txe, oe;
	logic [7:0] io_wdata, io_rdata, tx_d, rx_d;
	int n_fail = 0;
	int comparisons = 0;
	dual_serial_channel_ctrl dut (.mclk(mclk), .rstn(rstn), .power_on_clear_n(power_on_clear_n),
		.bus_reset_n(bus_reset_n), .io_sel(io_sel), .io_addr0(io_addr0), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_oe(oe),
		.powerup_levels(LV), .port_swap(port_swap), .opt_select_eoc(opt_select_eoc),
		.uart_rx_data(rx_d), .uart_rx_char_ready(rdy), .uart_tx_holding_empty(emp),
		.uart_parity_fault(pe), .uart_overrun(ov), .uart_framing_fault(fe),
		.uart_end_of_char(eoc), .uart_rx_read(rd_p), .uart_tx_load(ld), .uart_tx_data(tx_d),
		.stop_bit_count_select(sb), .parity_inhibit(pi), .parity_even_select(pev),
		.char_length_select(cl), .cd_out(cd_out), .ca_out(ca_out), .cc_in(cc_in),
		.cb_in(cb_in), .cf_in(cf_in), .rx_irq_line_out(rxo), .rx_irq_line_oe(rxe),
		.tx_irq_line_out(txo), .tx_irq_line_oe(txe));
	uart_flag_model partner (.mclk(mclk), .uart_rx_read(rd_p), .uart_tx_load(ld),
		.rx_push(rx_push), .rx_char_ready(rdy), .tx_holding_empty(emp));
	always #20 mclk = ~mclk;
	task final_report;
		if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task chk1(input logic got, input logic exp);
		chk8({7'h0, got}, {7'h0, exp});
	endtask
	task chk_ctl(input logic [7:0] w);
		chk8({cl, pev, pi, sb, ca_out, cd_out, 2'h0}, (w ^ LV) & 8'hFC);
	endtask
	task access(input logic wr, input logic a0, input logic [7:0] d);
		@(negedge mclk);
		io_sel = 1'b1;
		io_wr = wr;
		io_rd = !wr;
		io_addr0 = a0;
		io_wdata = d;
		@(negedge mclk);
		io_sel = 1'b0;
		io_wr = 1'b0;
		io_rd = 1'b0;
	endtask
	task rd(input logic a0, input logic [7:0] exp);
		access(1'b0, a0, 8'h00);
		chk1(oe, 1'b1);
		chk8(io_rdata, exp);
	endtask
	task wait_irq(input logic rx, input logic exp);
		int i;
		for (i = 0; i < 20 && (rx ? rxe : txe) !== exp; i++) @(negedge mclk);
		chk1(rx ? rxe : txe, exp);
		if (i == 20) final_report();
	endtask
	task t_ctrl;
		chk_ctl(8'h00); // Straps at power-up
		access(1'b1, 1'b1, 8'hFF);
		chk_ctl(8'hFF); // Bits 7 to 2 invert at once
		access(1'b1, 1'b1, 8'h30);
		chk_ctl(8'h30); // Mixed word
		access(1'b1, 1'b1, 8'h00);
		chk_ctl(8'h00); // Zero restores
	endtask
	task t_status;
		repeat (4) @(negedge mclk);
		rd(1'b1, 8'h6D); // Status layout with line detect
		opt_select_eoc = 1'b1;
		repeat (4) @(negedge mclk);
		rd(1'b1, 8'h69); // End of character shown
		port_swap = 1'b1;
		repeat (4) @(negedge mclk);
		rd(1'b0, 8'h69); // Swapped placement
		port_swap = 1'b0;
		repeat (4) @(negedge mclk);
	endtask
	task t_data;
		access(1'b1, 1'b0, 8'hC3);
		chk1(ld, 1'b1); // Data write loads UART
		chk8(tx_d, 8'hC3);
		rd(1'b0, 8'h5A); // Data read from UART
		chk1(rd_p, 1'b1);
	endtask
	task push;
		rx_push = 1'b1;
		@(negedge mclk);
		rx_push = 1'b0;
	endtask
	task t_irq;
		push();
		wait_irq(1'b1, 1'b1); // Receive interrupt
		chk1(rxo, 1'b0); // Pulled low when driven
		rd(1'b0, 8'h5A);
		wait_irq(1'b1, 1'b0); // Released after read
		access(1'b1, 1'b1, 8'h01);
		push();
		repeat (6) @(negedge mclk);
		chk1(rxe, 1'b0); // Receive enable inverted off
		chk1(txe, 1'b0); // Transmit disabled by strap
		access(1'b1, 1'b1, 8'h03);
		wait_irq(1'b0, 1'b1); // Transmit enable inverted on
		chk1(txo, 1'b0); // Pulled low when driven
		access(1'b1, 1'b0, 8'h11);
		wait_irq(1'b0, 1'b0); // Holding buffer full
		wait_irq(1'b0, 1'b1); // Empty again
		access(1'b1, 1'b1, 8'h00);
		wait_irq(1'b1, 1'b1); // Zero restores receive enable
	endtask
	task t_clear;
		for (int i = 0; i < 2; i++) begin
			access(1'b1, 1'b1, 8'hFF);
			bus_reset_n = i[0];
			power_on_clear_n = !i[0];
			repeat (5) @(negedge mclk);
			chk_ctl(8'h00); // Either clear restores straps
			access(1'b1, 1'b1, 8'hFF);
			chk_ctl(8'h00); // Write ignored during clear
			bus_reset_n = 1'b1;
			power_on_clear_n = 1'b1;
			repeat (4) @(negedge mclk);
		end
	endtask
	initial begin
		{mclk, rstn, io_sel, io_addr0, io_wr, io_rd, port_swap, opt_select_eoc, rx_push} = '0;
		{power_on_clear_n, bus_reset_n, pe, ov, fe, eoc, cc_in, cb_in, cf_in} = 9'h1D5;
		io_wdata = 8'h00;
		rx_d = 8'h5A;
		repeat (12) @(negedge mclk);
		rstn = 1'b1;
		repeat (8) @(negedge mclk);
		t_ctrl();
		t_status();
		t_data();
		t_irq();
		t_clear();
		final_report();
	end
endmodule // dual_serial_channel_ctrl_tb
